// ### hw/fbrg_top.sv
// register file and per-channel fractional rate generators
`timescale 1ns/1ps
// Behaviour
// - each channel owns its generator; shared oscillator
// - register access never waits on oscillator
// - modem control bit 7 prescales by four
// - divide by one to 65536 less sixteenth
// - output is 16x or 8x sampling tick
// - reset loads divisor of exactly one
// - integer divisor is high byte, low byte
// - only four fraction bits, adding sixteenths
// - enhanced mode bit 7 picks 16x sampling
// - 8x with odd fraction jitters bit time
// - zero integer divisor reads identity codes
module fbrg_top
	import fbrg_pkg::*;
#(
	parameter int         NCH    = 2,
	parameter logic [7:0] DEV_ID = 8'h5c, // arbitrary value
	parameter logic [7:0] REV_ID = 8'h01  // arbitrary value
)(
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rst_b,
	// oscillator or external clock edge, one cycle per edge
	input  wire logic           osc_tick,
	// host register port
	input  wire logic [NCH-1:0] chan_sel,
	input  wire logic [2:0]     addr,
	input  wire logic           wr_en,
	input  wire logic           rd_en,
	input  wire logic [7:0]     wdata,
	output logic      [7:0]     rdata,
	output logic                rd_valid,
	// sampling ticks to transmitter and receiver
	output logic      [NCH-1:0] sample_tick,
	output logic      [NCH-1:0] bit_tick
);
	typedef struct packed {
		logic [NCH-1:0][7:0] div_low;
		logic [NCH-1:0][7:0] div_high;
		logic [NCH-1:0][7:0] div_frac;
		logic [NCH-1:0][7:0] modem_ctrl;
		logic [NCH-1:0][7:0] enh_mode;
		logic [7:0]          rdata;
		logic                rd_valid;
	} fbrg_top_state_t;

	fbrg_top_state_t s_reg;
	fbrg_top_state_t s_next;
	logic [1:0]      rst_pipe;
	logic            rst_sync_b;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe[1];

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] rv;
		logic       found;
		rv     = 8'h00;
		found  = 1'b0;
		s_next = s_reg;
		s_next.rd_valid = 1'b0;
		// writes only touch storage, so they need no oscillator edge
		for (int c = 0; c < NCH; c++) begin
			if (wr_en && chan_sel[c]) begin
				case (addr)
					ADDR_DIV_LOW:    s_next.div_low[c]    = wdata;
					ADDR_DIV_HIGH:   s_next.div_high[c]   = wdata;
					ADDR_DIV_FRAC:   s_next.div_frac[c]   = wdata & FRAC_MASK;
					ADDR_MODEM_CTRL: s_next.modem_ctrl[c] = wdata;
					ADDR_ENH_MODE:   s_next.enh_mode[c]   = wdata;
					default:         ;
				endcase
			end
		end
		// reading several channels at once is not meaningful; lowest wins
		for (int c = 0; c < NCH; c++) begin
			if (chan_sel[c] && !found) begin
				found = 1'b1;
				case (addr)
					ADDR_DIV_LOW: begin
						if (fbrg_int_div(s_reg.div_high[c], s_reg.div_low[c]) == 16'h0000) begin
							rv = REV_ID;
						end else begin
							rv = s_reg.div_low[c];
						end
					end
					ADDR_DIV_HIGH: begin
						if (fbrg_int_div(s_reg.div_high[c], s_reg.div_low[c]) == 16'h0000) begin
							rv = DEV_ID;
						end else begin
							rv = s_reg.div_high[c];
						end
					end
					ADDR_DIV_FRAC:   rv = s_reg.div_frac[c];
					ADDR_MODEM_CTRL: rv = s_reg.modem_ctrl[c];
					ADDR_ENH_MODE:   rv = s_reg.enh_mode[c];
					default:         rv = 8'h00;
				endcase
			end
		end
		if (rd_en) begin
			s_next.rdata    = rv;
			s_next.rd_valid = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			for (int c = 0; c < NCH; c++) begin
				s_reg.div_low[c]    <= DIV_LOW_RST;
				s_reg.div_high[c]   <= DIV_HIGH_RST;
				s_reg.div_frac[c]   <= DIV_FRAC_RST;
				s_reg.modem_ctrl[c] <= MODEM_CTRL_RST;
				s_reg.enh_mode[c]   <= ENH_MODE_RST;
			end
			s_reg.rdata    <= 8'h00;
			s_reg.rd_valid <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata    = s_reg.rdata;
	assign rd_valid = s_reg.rd_valid;

	// ------------------------------------------------------------
	// one generator per channel, all on the shared oscillator
	// ------------------------------------------------------------
	for (genvar c = 0; c < NCH; c++) begin : gen_ch
		fbrg_cfg_if cfg ();
		assign cfg.pre4     = s_reg.modem_ctrl[c][PRESCALE_BIT];
		assign cfg.div_int  = fbrg_int_div(s_reg.div_high[c], s_reg.div_low[c]);
		assign cfg.div_frac = s_reg.div_frac[c][3:0];
		// 8x with an odd fraction cannot close the sixteenths inside one bit
		assign cfg.mode16   = s_reg.enh_mode[c][SAMPLE16_BIT];
		fbrg_divider u_div (
			.clk        (clk),
			.rst_sync_b (rst_sync_b),
			.osc_tick   (osc_tick),
			.g          (cfg)
		);
		assign sample_tick[c] = cfg.sample_tick;
		assign bit_tick[c]    = cfg.bit_tick;
	end

	// ------------------------------------------------------------
	// checks on channel 0
	// ------------------------------------------------------------
	sequence s_release;
		$rose(rst_sync_b);
	endsequence

	sequence s_rd_zero(logic [2:0] a);
		rd_en && chan_sel[0] && addr == a && s_reg.div_low[0] == 8'h00 && s_reg.div_high[0] == 8'h00;
	endsequence

	property p_reset_div;
		@(posedge clk) s_release |-> s_reg.div_low[0] == DIV_LOW_RST &&
			s_reg.div_high[0] == DIV_HIGH_RST && s_reg.div_frac[0] == DIV_FRAC_RST;
	endproperty
	a_reset_div: assert property (p_reset_div) else $error("divisor not one after reset");

	property p_id_high;
		@(posedge clk) disable iff (!rst_sync_b) s_rd_zero(ADDR_DIV_HIGH) |=> rd_valid && rdata == DEV_ID;
	endproperty
	a_id_high: assert property (p_id_high) else $error("identity code not returned");

	property p_id_low;
		@(posedge clk) disable iff (!rst_sync_b) s_rd_zero(ADDR_DIV_LOW) |=> rd_valid && rdata == REV_ID;
	endproperty
	a_id_low: assert property (p_id_low) else $error("revision code not returned");

	property p_frac_bits;
		@(posedge clk) disable iff (!rst_sync_b)
			(rd_en && chan_sel[0] && addr == ADDR_DIV_FRAC) |=> rdata[7:4] == 4'h0;
	endproperty
	a_frac_bits: assert property (p_frac_bits) else $error("fraction upper bits not zero");

	property p_pre_cfg;
		@(posedge clk) disable iff (!rst_sync_b)
			(wr_en && chan_sel[0] && addr == ADDR_MODEM_CTRL) |=> gen_ch[0].cfg.pre4 == $past(wdata[7]);
	endproperty
	a_pre_cfg: assert property (p_pre_cfg) else $error("prescale select not taken");

	property p_div_cfg;
		@(posedge clk) disable iff (!rst_sync_b)
			(wr_en && chan_sel[0] && addr == ADDR_DIV_HIGH) |=> gen_ch[0].cfg.div_int[15:8] == $past(wdata);
	endproperty
	a_div_cfg: assert property (p_div_cfg) else $error("high byte not upper divisor");

	property p_mode_cfg;
		@(posedge clk) disable iff (!rst_sync_b)
			(wr_en && chan_sel[0] && addr == ADDR_ENH_MODE) |=> gen_ch[0].cfg.mode16 == $past(wdata[7]);
	endproperty
	a_mode_cfg: assert property (p_mode_cfg) else $error("sampling mode not taken");
endmodule : fbrg_top

// ### hw/fbrg_pkg.sv
// constants shared by the fractional rate generator files
package fbrg_pkg;
	// ------------------------------------------------------------
	// register addresses inside one channel
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_DIV_LOW    = 3'h0;
	localparam logic [2:0] ADDR_DIV_HIGH   = 3'h1;
	localparam logic [2:0] ADDR_DIV_FRAC   = 3'h2;
	localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
	localparam logic [2:0] ADDR_ENH_MODE   = 3'h5;
	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] DIV_LOW_RST    = 8'h01;
	localparam logic [7:0] DIV_HIGH_RST   = 8'h00;
	localparam logic [7:0] DIV_FRAC_RST   = 8'h00;
	localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
	localparam logic [7:0] ENH_MODE_RST   = 8'h00;
	localparam int         PRESCALE_BIT   = 7;
	localparam int         SAMPLE16_BIT   = 7;
	localparam logic [7:0] FRAC_MASK      = 8'h0f;
	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam logic [1:0] PRESCALE_LAST  = 2'h3;
	localparam logic [3:0] SAMPLES16_LAST = 4'hf;
	localparam logic [3:0] SAMPLES8_LAST  = 4'h7;

	function automatic logic [15:0] fbrg_int_div(input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo};
	endfunction : fbrg_int_div
endpackage : fbrg_pkg

// ### hw/fbrg_cfg_if.sv
// carrier between the register file and one channel's generator
`timescale 1ns/1ps
interface fbrg_cfg_if;
	logic        pre4;
	logic [15:0] div_int;
	logic [3:0]  div_frac;
	logic        mode16;
	logic        sample_tick;
	logic        bit_tick;
	modport regs (output pre4, output div_int, output div_frac, output mode16,
		input sample_tick, input bit_tick);
	modport gen (input pre4, input div_int, input div_frac, input mode16,
		output sample_tick, output bit_tick);
endinterface : fbrg_cfg_if

// ### hw/fbrg_divider.sv
// prescaler and fractional divider of one channel
`timescale 1ns/1ps
module fbrg_divider
	import fbrg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// oscillator edge indicator
	input wire logic osc_tick,
	// configuration and ticks
	fbrg_cfg_if.gen  g
);
	typedef struct packed {
		logic [1:0]  pre_cnt;
		logic [15:0] cnt;
		logic [3:0]  acc;
		logic [3:0]  samp_cnt;
		logic        sample;
		logic        bit_t;
	} fbrg_div_state_t;

	fbrg_div_state_t s_reg;
	fbrg_div_state_t s_next;
	logic            pre_tick;
	logic            emit;
	logic [4:0]      sum;
	logic [3:0]      last;

	// ------------------------------------------------------------
	// datapath
	// ------------------------------------------------------------
	assign pre_tick = osc_tick && (!g.pre4 || s_reg.pre_cnt == PRESCALE_LAST);
	assign emit     = pre_tick && g.div_int != 16'h0000 && s_reg.cnt == 16'h0000;
	assign sum      = {1'b0, s_reg.acc} + {1'b0, g.div_frac};
	assign last     = g.mode16 ? SAMPLES16_LAST : SAMPLES8_LAST;

	always_comb begin
		s_next        = s_reg;
		s_next.sample = 1'b0;
		s_next.bit_t  = 1'b0;
		if (osc_tick) begin
			s_next.pre_cnt = g.pre4 ? s_reg.pre_cnt + 2'h1 : 2'h0;
		end
		if (pre_tick) begin
			if (g.div_int == 16'h0000) begin
				// an integer of zero parks the generator
				s_next.cnt = 16'h0000;
			end else if (s_reg.cnt == 16'h0000) begin
				// a carry out of the sixteenths stretches this period by one prescaled edge
				s_next.acc    = sum[3:0];
				s_next.cnt    = g.div_int - 16'h0001 + {15'h0000, sum[4]};
				s_next.sample = 1'b1;
				if (s_reg.samp_cnt >= last) begin
					s_next.samp_cnt = 4'h0;
					s_next.bit_t    = 1'b1;
				end else begin
					s_next.samp_cnt = s_reg.samp_cnt + 4'h1;
				end
			end else begin
				s_next.cnt = s_reg.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// one tick serves both transmitter and receiver of the channel
	assign g.sample_tick = s_reg.sample;
	assign g.bit_tick    = s_reg.bit_t;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [16:0] gap_cnt;
	logic [16:0] gap_last;
	logic [16:0] len_cur;
	logic [16:0] chk_len;
	logic [1:0]  primed;
	logic [4:0]  sb_cnt;
	logic        b_clean;
	logic [1:0]  osc_seen;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			gap_cnt  <= 17'h0;
			gap_last <= 17'h0;
			len_cur  <= 17'h0;
			chk_len  <= 17'h0;
			primed   <= 2'h0;
			sb_cnt   <= 5'h0;
			b_clean  <= 1'b0;
			osc_seen <= 2'h0;
		end else begin
			if (pre_tick && g.div_int == 16'h0000) begin
				primed <= 2'h0;
			end else if (emit) begin
				gap_last <= gap_cnt + 17'h1;
				gap_cnt  <= 17'h0;
				chk_len  <= len_cur;
				len_cur  <= {1'b0, g.div_int} + {16'h0000, sum[4]};
				primed   <= (primed == 2'h2) ? primed : primed + 2'h1;
			end else if (pre_tick) begin
				gap_cnt <= gap_cnt + 17'h1;
			end
			if (g.bit_tick) begin
				sb_cnt  <= 5'h0;
				b_clean <= 1'b1;
			end else if (g.sample_tick) begin
				sb_cnt <= sb_cnt + 5'h1;
			end
			// own edge count, so the prescale check does not lean on pre_cnt
			if (pre_tick) begin
				osc_seen <= 2'h0;
			end else if (osc_tick) begin
				osc_seen <= osc_seen + 2'h1;
			end
			if (g.mode16 != $past(g.mode16)) begin
				b_clean <= 1'b0;
			end
		end
	end

	property p_pre_div1;
		@(posedge clk) disable iff (!rst_sync_b) (osc_tick && !g.pre4) |-> pre_tick;
	endproperty
	a_pre_div1: assert property (p_pre_div1) else $error("prescale 1 dropped an edge");

	property p_pre_div4;
		@(posedge clk) disable iff (!rst_sync_b)
			(g.pre4 && pre_tick) |-> osc_seen == 2'h3;
	endproperty
	a_pre_div4: assert property (p_pre_div4) else $error("prescale 4 passed early edge");

	property p_samp_align;
		@(posedge clk) disable iff (!rst_sync_b) g.sample_tick |-> $past(pre_tick);
	endproperty
	a_samp_align: assert property (p_samp_align) else $error("sample tick not on prescaled edge");

	property p_zero_stop;
		@(posedge clk) disable iff (!rst_sync_b)
			(g.div_int == 16'h0000)[*2] |-> !g.sample_tick;
	endproperty
	a_zero_stop: assert property (p_zero_stop) else $error("sample tick with zero divisor");

	property p_period;
		@(posedge clk) disable iff (!rst_sync_b)
			(g.sample_tick && primed == 2'h2) |-> gap_last == chk_len;
	endproperty
	a_period: assert property (p_period) else $error("period length differs from loaded length");

	property p_len;
		@(posedge clk) disable iff (!rst_sync_b)
			g.sample_tick |-> (len_cur == {1'b0, $past(g.div_int)}) ||
				(len_cur == {1'b0, $past(g.div_int)} + 17'h1);
	endproperty
	a_len: assert property (p_len) else $error("period outside divisor or divisor plus one");

	property p_len_frac0;
		@(posedge clk) disable iff (!rst_sync_b)
			(g.sample_tick && $past(g.div_frac) == 4'h0 && $past(s_reg.acc) == 4'h0)
				|-> len_cur == {1'b0, $past(g.div_int)};
	endproperty
	a_len_frac0: assert property (p_len_frac0) else $error("zero fraction stretched a period");

	property p_bit_len;
		@(posedge clk) disable iff (!rst_sync_b)
			(g.bit_tick && b_clean && $stable(g.mode16)) |->
				(sb_cnt + 5'h1 == (g.mode16 ? 5'h10 : 5'h08)) && g.sample_tick;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bit time not 16 or 8 samples");
endmodule : fbrg_divider

// ### verification/fbrg_tb.sv
// self-checking bench for the fractional rate generator top
`timescale 1ns/1ps
module fbrg_tb;
	import fbrg_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [7:0] TB_DEV_ID = 8'h3a; // arbitrary value
	localparam logic [7:0] TB_REV_ID = 8'h02; // arbitrary value
	logic       clk;
	logic       rst_b;
	logic       osc_tick;
	logic [1:0] chan_sel;
	logic [2:0] addr;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rd_valid;
	logic [1:0] sample_tick;
	logic [1:0] bit_tick;
	int         err_count;
	int         n_compared;
	int         ch;
	int         got;

	fbrg_top #(.NCH(2), .DEV_ID(TB_DEV_ID), .REV_ID(TB_REV_ID)) dut (
		.clk        (clk),
		.rst_b      (rst_b),
		.osc_tick   (osc_tick),
		.chan_sel   (chan_sel),
		.addr       (addr),
		.wr_en      (wr_en),
		.rd_en      (rd_en),
		.wdata      (wdata),
		.rdata      (rdata),
		.rd_valid   (rd_valid),
		.sample_tick(sample_tick),
		.bit_tick   (bit_tick)
	);

	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk8

	task automatic chk_cnt(input int g, input int e);
		n_compared++;
		if (g != e) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_cnt

	task automatic timed_out();
		chk_cnt(0, 1);
		complete_run();
	endtask : timed_out

	// ------------------------------------------------------------
	// register access, driven on the falling edge
	// ------------------------------------------------------------
	task automatic reg_wr(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		chan_sel = sel;
		addr     = a;
		wdata    = d;
		wr_en    = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : reg_wr

	task automatic rd_chk(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] e);
		int n;
		@(negedge clk);
		chan_sel = sel;
		addr     = a;
		rd_en    = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		if (rd_valid !== 1'b1) timed_out();
		chk8(rdata, e);
	endtask : rd_chk

	// ------------------------------------------------------------
	// tick measurement; a stopped generator ends the run
	// ------------------------------------------------------------
	task automatic span(input int c, input int nt, output int cyc);
		int k;
		cyc = 0;
		while (sample_tick[c] !== 1'b1 && cyc < 40000) begin
			@(negedge clk);
			cyc++;
		end
		if (cyc >= 40000) timed_out();
		cyc = 0;
		k   = 0;
		while (k < nt && cyc < 40000) begin
			@(negedge clk);
			cyc++;
			if (sample_tick[c] === 1'b1) k++;
		end
		if (k < nt) timed_out();
	endtask : span

	// samples from one bit tick to the next, the second bit after a mode change
	task automatic bit_len(input int c, output int s);
		int n;
		for (int b = 0; b < 3; b++) begin
			s = 0;
			n = 0;
			do begin
				@(negedge clk);
				n++;
				if (sample_tick[c] === 1'b1) s++;
			end while (bit_tick[c] !== 1'b1 && n < 400);
			if (n >= 400) timed_out();
		end
	endtask : bit_len

	task automatic run_case(input int c, input logic [7:0] lo, hi, fr, md, input int e);
		logic [1:0] sel;
		int         cyc;
		sel = 2'b01 << c;
		reg_wr(sel, ADDR_DIV_LOW, lo);
		reg_wr(sel, ADDR_DIV_HIGH, hi);
		reg_wr(sel, ADDR_DIV_FRAC, fr);
		reg_wr(sel, ADDR_MODEM_CTRL, md);
		// the period in flight may still mix old settings
		span(c, 2, cyc);
		span(c, 16, cyc);
		chk_cnt(cyc, e);
	endtask : run_case

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk        = 1'b0;
		rst_b      = 1'b1;
		osc_tick   = 1'b0;
		chan_sel   = 2'h0;
		addr       = 3'h0;
		wr_en      = 1'b0;
		rd_en      = 1'b0;
		wdata      = 8'h00;
		err_count  = 0;
		n_compared = 0;
		// a real falling edge on rst_b, not a time-zero race with the synchroniser
		@(negedge clk);
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		// oscillator stopped: host access must still work
		for (ch = 0; ch < 2; ch++) begin
			rd_chk(2'b01 << ch, ADDR_DIV_LOW, 8'h01);
			rd_chk(2'b01 << ch, ADDR_DIV_FRAC, 8'h00);
			rd_chk(2'b01 << ch, ADDR_MODEM_CTRL, 8'h00);
			rd_chk(2'b01 << ch, ADDR_ENH_MODE, 8'h00);
		end
		for (int a = 3; a < 8; a += (a == 3) ? 3 : 1) begin
			reg_wr(2'b01, a[2:0], 8'hff);
			rd_chk(2'b01, a[2:0], 8'h00);
		end
		reg_wr(2'b11, ADDR_DIV_LOW, 8'h5a);
		reg_wr(2'b01, ADDR_DIV_HIGH, 8'ha5);
		reg_wr(2'b10, ADDR_DIV_FRAC, 8'hff);
		rd_chk(2'b01, ADDR_DIV_LOW, 8'h5a);
		rd_chk(2'b01, ADDR_DIV_HIGH, 8'ha5);
		rd_chk(2'b10, ADDR_DIV_LOW, 8'h5a);
		rd_chk(2'b10, ADDR_DIV_HIGH, 8'h00);
		rd_chk(2'b10, ADDR_DIV_FRAC, 8'h0f);
		rd_chk(2'b01, ADDR_DIV_FRAC, 8'h00);
		// zero integer divisor exposes the identity codes
		reg_wr(2'b11, ADDR_DIV_LOW, 8'h00);
		reg_wr(2'b11, ADDR_DIV_HIGH, 8'h00);
		for (ch = 0; ch < 2; ch++) begin
			rd_chk(2'b01 << ch, ADDR_DIV_HIGH, TB_DEV_ID);
			rd_chk(2'b01 << ch, ADDR_DIV_LOW, TB_REV_ID);
		end
		// a second reset brings back a divisor of one
		@(negedge clk);
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		rd_chk(2'b10, ADDR_DIV_LOW, 8'h01);
		rd_chk(2'b10, ADDR_DIV_HIGH, 8'h00);
		osc_tick = 1'b1;
		span(1, 16, got);
		chk_cnt(got, 16);
		run_case(0, 8'h03, 8'h00, 8'h05, 8'h00, 53);
		run_case(0, 8'h01, 8'h00, 8'h0f, 8'h00, 31);
		run_case(0, 8'h02, 8'h00, 8'h00, 8'h80, 128);
		run_case(0, 8'h02, 8'h00, 8'h0f, 8'h80, 188);
		run_case(1, 8'h02, 8'h01, 8'h00, 8'h00, 4128);
		span(0, 16, got);
		chk_cnt(got, 188);
		run_case(0, 8'h01, 8'h00, 8'h00, 8'h00, 16);
		bit_len(0, got);
		chk_cnt(got, 8);
		reg_wr(2'b01, ADDR_ENH_MODE, 8'h80);
		bit_len(0, got);
		chk_cnt(got, 16);
		rd_chk(2'b01, ADDR_ENH_MODE, 8'h80);
		// zero integer divisor with the oscillator running: generator parks
		reg_wr(2'b01, ADDR_DIV_LOW, 8'h00);
		got = 0;
		repeat (40) begin
			@(negedge clk);
			if (sample_tick[0] !== 1'b0) got++;
		end
		chk_cnt(got, 0);
		rd_chk(2'b01, ADDR_DIV_HIGH, TB_DEV_ID);
		complete_run();
	end
endmodule : fbrg_tb
